// file: ppes_sequencer.v
// enable and power-up sequencer for a charging port buck converter
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ns
`include "ppes_regs.vh"

module ppes_sequencer #(
    parameter ENABLE_RETRY_CYC = `PPES_ENABLE_RETRY_CYC,
    parameter DETACH_RETRY_CYC = `PPES_DETACH_RETRY_CYC
)
(
    input wire core_clk,
    input wire rst_b,
    input wire system_enable_pin,
    input wire converter_enable_pin,
    input wire switch_supply_good,
    input wire internal_supply_good,
    input wire standalone_variant,
    input wire sink_attached,
    input wire typec_3a_capable,
    input wire typec_1a5_capable,
    input wire bc12_detected,
    input wire usb3_default,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    output wire converter_on,
    output wire isolation_gate_drive,
    output wire regulator_on,
    output wire standby,
    output wire attention,
    output reg [1:0] charge_mode,
    output wire irq
);

    // ------------------------------------------------------------------
    // charge modes, highest precedence first
    // ------------------------------------------------------------------
    localparam [1:0] MODE_C3A = 2'h0;
    localparam [1:0] MODE_C1A5 = 2'h1;
    localparam [1:0] MODE_BC12 = 2'h2;
    localparam [1:0] MODE_DEFAULT = 2'h3;

    // sequencer states
    localparam [1:0] ST_OFF = 2'h0;
    localparam [1:0] ST_WAIT = 2'h1;
    localparam [1:0] ST_ON = 2'h2;
    localparam [1:0] ST_HOLD = 2'h3;

    reg sys_en_meta;
    reg sys_en_sync;
    reg conv_en_meta;
    reg conv_en_sync;
    reg sys_en_last;
    reg conv_en_bit;
    reg setup_done;
    reg bypass;
    reg unconfigured;
    reg pin_low_lock;
    reg permit_last;
    reg attach_last;
    reg [1:0] state;
    reg [1:0] next_state;
    reg [`PPES_CNT_W-1:0] hold_cnt;
    reg [`PPES_CNT_W-1:0] next_hold_cnt;
    reg [`PPES_EV_W-1:0] irq_status;
    reg [`PPES_EV_W-1:0] irq_enable;
    wire core_alive;
    wire bit_eff;
    wire permit;
    wire attached;
    wire may_run;
    wire permit_fall;
    wire detach;
    wire [`PPES_EV_W-1:0] events;
    wire wr_ctrl;
    wire wr_clear;

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    // first flop feeds only the second, to keep metastability contained
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sys_en_meta <= 1'b0;
            sys_en_sync <= 1'b0;
            conv_en_meta <= 1'b0;
            conv_en_sync <= 1'b0;
        end
        else
        begin
            sys_en_meta <= system_enable_pin;
            sys_en_sync <= sys_en_meta;
            conv_en_meta <= converter_enable_pin;
            conv_en_sync <= conv_en_meta;
        end
    end

    // ------------------------------------------------------------------
    // supply and enable combination
    // ------------------------------------------------------------------
    // regulator follows enable and switch supply; logic needs the rail good too
    assign regulator_on = sys_en_sync & switch_supply_good;
    assign standby = ~sys_en_sync;
    assign core_alive = regulator_on & internal_supply_good;
    assign bit_eff = standalone_variant | conv_en_bit;
    assign permit = conv_en_sync & bit_eff & ~pin_low_lock;
    // any sink termination is an attach, so legacy adapters count too
    assign attached = bypass | sink_attached;
    assign may_run = permit & attached & (standalone_variant | setup_done);
    assign permit_fall = permit_last & ~permit;
    assign detach = attach_last & ~attached;
    assign attention = unconfigured & ~standalone_variant;
    assign wr_ctrl = reg_wr && (reg_addr == `PPES_ADDR_CTRL);
    assign wr_clear = reg_wr && (reg_addr == `PPES_ADDR_IRQ_CLEAR);

    // ------------------------------------------------------------------
    // control bits, system reset on enable drop or rail loss
    // ------------------------------------------------------------------
    // a lost rail wipes configuration just like a pin reset would
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            conv_en_bit <= 1'b0;
            setup_done <= 1'b0;
            bypass <= 1'b0;
            unconfigured <= 1'b1;
            pin_low_lock <= 1'b0;
            sys_en_last <= 1'b0;
            permit_last <= 1'b0;
            attach_last <= 1'b0;
        end
        else
        begin
            sys_en_last <= sys_en_sync;
            permit_last <= permit;
            attach_last <= attached;
            if (!core_alive)
            begin
                conv_en_bit <= 1'b0;
                setup_done <= 1'b0;
                bypass <= 1'b0;
                unconfigured <= 1'b1;
                permit_last <= 1'b0;
                attach_last <= 1'b0;
            end
            else
            begin
                if (wr_ctrl)
                begin
                    conv_en_bit <= reg_wdata[`PPES_CTRL_CONV_EN];
                    bypass <= reg_wdata[`PPES_CTRL_BYPASS];
                    if (reg_wdata[`PPES_CTRL_SETUP_DONE])
                    begin
                        setup_done <= 1'b1;
                        unconfigured <= 1'b0;
                    end
                end
            end
            // enable pin low at start-up locks until the pin rises
            if (sys_en_sync && !sys_en_last && !conv_en_sync)
                pin_low_lock <= 1'b1;
            else if (conv_en_sync)
                pin_low_lock <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // sequencer with retry hold-off
    // ------------------------------------------------------------------
    // detach delay wins if both strike together, though both delays default to the same length
    always @*
    begin
        next_state = state;
        next_hold_cnt = hold_cnt;
        case (state)
            ST_OFF:
            begin
                if (core_alive)
                    next_state = ST_WAIT;
            end
            ST_WAIT:
            begin
                if (!core_alive)
                    next_state = ST_OFF;
                else if (may_run)
                    next_state = ST_ON;
            end
            ST_ON:
            begin
                if (!core_alive)
                    next_state = ST_OFF;
                else if (detach)
                begin
                    next_state = ST_HOLD;
                    next_hold_cnt = DETACH_RETRY_CYC[`PPES_CNT_W-1:0] - 1'b1;
                end
                else if (permit_fall)
                begin
                    next_state = ST_HOLD;
                    next_hold_cnt = ENABLE_RETRY_CYC[`PPES_CNT_W-1:0] - 1'b1;
                end
                else if (!may_run)
                    next_state = ST_WAIT;
            end
            ST_HOLD:
            begin
                if (!core_alive)
                    next_state = ST_OFF;
                else if (hold_cnt == {`PPES_CNT_W{1'b0}})
                    next_state = ST_WAIT;
                else
                    next_hold_cnt = hold_cnt - 1'b1;
            end
            default:
                next_state = ST_OFF;
        endcase
    end

    // state flops
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= ST_OFF;
            hold_cnt <= {`PPES_CNT_W{1'b0}};
        end
        else
        begin
            state <= next_state;
            hold_cnt <= next_hold_cnt;
        end
    end

    // converter only while running and still allowed, gate while running and attached
    assign converter_on = (state == ST_ON) & may_run;
    assign isolation_gate_drive = (state == ST_ON) & attached;

    // ------------------------------------------------------------------
    // charge mode precedence
    // ------------------------------------------------------------------
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            charge_mode <= MODE_DEFAULT;
        else if (typec_3a_capable)
            charge_mode <= MODE_C3A;
        else if (typec_1a5_capable)
            charge_mode <= MODE_C1A5;
        else if (bc12_detected)
            charge_mode <= MODE_BC12;
        else
            charge_mode <= MODE_DEFAULT;
    end

    // ------------------------------------------------------------------
    // interrupts: sticky status, write-one clear, enable
    // ------------------------------------------------------------------
    assign events[`PPES_EV_ATTACH] = attached & ~attach_last;
    assign events[`PPES_EV_DETACH] = detach;
    assign events[`PPES_EV_PERMIT_LOST] = permit_fall;
    assign events[`PPES_EV_CONV_ON] = (next_state == ST_ON) & (state != ST_ON);

    genvar gi;
    generate
        for (gi = 0; gi < `PPES_EV_W; gi = gi + 1)
        begin : g_irq
            // a set in the clearing cycle survives
            always @(posedge core_clk or negedge rst_b)
            begin
                if (!rst_b)
                    irq_status[gi] <= 1'b0;
                else if (events[gi])
                    irq_status[gi] <= 1'b1;
                else if (wr_clear && reg_wdata[gi])
                    irq_status[gi] <= 1'b0;
            end
        end
    endgenerate

    // enable register
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            irq_enable <= {`PPES_EV_W{1'b0}};
        else if (reg_wr && (reg_addr == `PPES_ADDR_IRQ_ENABLE))
            irq_enable <= reg_wdata[`PPES_EV_W-1:0];
    end

    assign irq = |(irq_status & irq_enable);

    // ------------------------------------------------------------------
    // read port, data one cycle after the strobe
    // ------------------------------------------------------------------
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            case (reg_addr)
                `PPES_ADDR_CTRL:
                    reg_rdata <= {5'h00, bypass, setup_done, bit_eff};
                `PPES_ADDR_STATUS:
                    reg_rdata <= {1'b0, (state == ST_HOLD), standby, unconfigured,
                        attached, isolation_gate_drive, converter_on, permit};
                `PPES_ADDR_IRQ_STATUS:
                    reg_rdata <= {4'h0, irq_status};
                `PPES_ADDR_IRQ_ENABLE:
                    reg_rdata <= {4'h0, irq_enable};
                default:
                    reg_rdata <= 8'h00;
            endcase
        end
        else
            reg_rdata <= 8'h00;
    end

endmodule

// file: ppes_regs.vh
// register map, field positions, reset values and timing counts of the port power sequencer
`ifndef PPES_REGS_VH
`define PPES_REGS_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define PPES_ADDR_CTRL 4'h0
`define PPES_ADDR_STATUS 4'h1
`define PPES_ADDR_IRQ_STATUS 4'h2
`define PPES_ADDR_IRQ_CLEAR 4'h3
`define PPES_ADDR_IRQ_ENABLE 4'h4

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define PPES_CTRL_CONV_EN 0
`define PPES_CTRL_SETUP_DONE 1
`define PPES_CTRL_BYPASS 2
`define PPES_CTRL_RESET 8'h00

// ----------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------
`define PPES_ST_PERMIT 0
`define PPES_ST_CONV_ON 1
`define PPES_ST_GATE_ON 2
`define PPES_ST_ATTACHED 3
`define PPES_ST_UNCONFIG 4
`define PPES_ST_STANDBY 5
`define PPES_ST_HOLDOFF 6

// ----------------------------------------------------------------------
// event bits
// ----------------------------------------------------------------------
`define PPES_EV_ATTACH 0
`define PPES_EV_DETACH 1
`define PPES_EV_PERMIT_LOST 2
`define PPES_EV_CONV_ON 3
`define PPES_EV_W 4

// ----------------------------------------------------------------------
// retry delays in microseconds, converted at 100 MHz
// ----------------------------------------------------------------------
`define PPES_CLK_MHZ 100
`define PPES_ENABLE_RETRY_US 1000
`define PPES_DETACH_RETRY_US 1000
`define PPES_ENABLE_RETRY_CYC (`PPES_ENABLE_RETRY_US * `PPES_CLK_MHZ)
`define PPES_DETACH_RETRY_CYC (`PPES_DETACH_RETRY_US * `PPES_CLK_MHZ)
`define PPES_CNT_W 20

`endif

// file: ppes_props.sv
// checker of sequencing relations at the sequencer ports
`timescale 1ns/1ns
module ppes_props #(
    parameter ENABLE_RETRY_CYC = 8,
    parameter DETACH_RETRY_CYC = 8
)
(
    input wire core_clk,
    input wire rst_b,
    input wire system_enable_pin,
    input wire converter_enable_pin,
    input wire switch_supply_good,
    input wire internal_supply_good,
    input wire standalone_variant,
    input wire sink_attached,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire converter_on,
    input wire isolation_gate_drive,
    input wire regulator_on,
    input wire standby,
    input wire attention
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // five samples leave room for the pin synchroniser
    sequence sys_low;
        !system_enable_pin [*5];
    endsequence
    sequence detach_on;
        // the gate only falls with the sink when the port really loses its attach
        $fell(sink_attached) && $fell(isolation_gate_drive);
    endsequence
    gate_with_conv_a:
    assert property (converter_on |-> isolation_gate_drive) else $error("converter on, gate off");
    pin_blocks_conv_a:
    assert property (!converter_enable_pin [*4] |-> !converter_on) else $error("pin low, conv on");
    sys_low_off_a:
    assert property (sys_low |-> standby && !regulator_on && !converter_on)
        else $error("system enable low but device active");
    sys_low_attn_a:
    assert property (sys_low ##0 !standalone_variant |-> attention) else $error("no attention");
    supply_reg_off_a:
    assert property (!switch_supply_good |-> !regulator_on) else $error("regulator on, supply low");
    supply_reg_on_a:
    assert property (system_enable_pin [*4] ##0 switch_supply_good |-> regulator_on)
        else $error("regulator stayed off");
    internal_uv_a:
    assert property (!internal_supply_good [*3] |-> !converter_on) else $error("conv on under uv");
    detach_hold_a:
    assert property (detach_on |=> !converter_on [*8]) else $error("detach hold too short");
    standalone_attn_a:
    assert property (standalone_variant |-> !attention) else $error("attention on standalone");
    rdata_idle_a:
    assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data not idle");
endmodule

// file: ppes_host.sv
// host controller model driving enable pins and the register port
`timescale 1ns/1ns
module ppes_host
(
    input wire core_clk,
    output logic system_enable_pin,
    output logic converter_enable_pin,
    output logic [3:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire [7:0] reg_rdata
);
    // both enables start high, as with always-on wiring
    initial
    begin
        system_enable_pin = 1'b1;
        converter_enable_pin = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task pins(input logic s, input logic c);
        @(posedge core_clk);
        system_enable_pin <= s;
        converter_enable_pin <= c;
    endtask
    // stale write data is inverted so nothing relies on it
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask
    // setup done goes last, once the other bits are in place
    task cfg(input logic [7:0] d);
        wr(4'h0, d & 8'hFD);
        wr(4'h0, d);
    endtask
endmodule

// file: tb_top.sv
// self-checking bench for the port power sequencer
`timescale 1ns/1ns
module tb_top;
    logic core_clk;
    logic rst_b;
    logic switch_supply_good;
    logic internal_supply_good;
    logic standalone_variant;
    logic sink_attached;
    logic [3:0] mode_in;
    logic [7:0] rd;
    wire system_enable_pin;
    wire converter_enable_pin;
    wire [3:0] reg_addr;
    wire [7:0] reg_wdata;
    wire reg_wr;
    wire reg_rd;
    wire [7:0] reg_rdata;
    wire converter_on;
    wire isolation_gate_drive;
    wire regulator_on;
    wire standby;
    wire attention;
    wire [1:0] charge_mode;
    wire irq;
    int n_errors;
    int cmp_count;
    ppes_host i_ppes_host (.core_clk, .system_enable_pin, .converter_enable_pin, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    // short retry delays keep the run brief
    ppes_sequencer #(.ENABLE_RETRY_CYC(8), .DETACH_RETRY_CYC(8)) i_ppes_sequencer (.core_clk,
        .rst_b, .system_enable_pin, .converter_enable_pin, .switch_supply_good,
        .internal_supply_good, .standalone_variant, .sink_attached,
        .typec_3a_capable(mode_in[3]), .typec_1a5_capable(mode_in[2]),
        .bc12_detected(mode_in[1]), .usb3_default(mode_in[0]), .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .converter_on, .isolation_gate_drive, .regulator_on, .standby,
        .attention, .charge_mode, .irq);
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task chk(input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task won(input logic e, input int n);
        int i;
        for (i = 0; i < n && converter_on !== e; i++)
            @(posedge core_clk);
        @(negedge core_clk);
        chk({7'h00, converter_on}, {7'h00, e});
    endtask
    task offn(input int n);
        repeat (n)
        begin
            @(negedge core_clk);
            chk({6'h00, isolation_gate_drive, converter_on}, 8'h00);
        end
    endtask
    task rchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        i_ppes_host.rd(a, rd);
        chk(rd & m, e);
    endtask
    task summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_boot;
        chk({7'h00, attention}, 8'h01);
        rchk(4'hF, 8'hFF, 8'h00);
        i_ppes_host.wr(4'h0, 8'h01);
        offn(20);
        i_ppes_host.cfg(8'h03);
        won(1'b1, 20);
        chk({7'h00, attention}, 8'h00);
        rchk(4'h0, 8'hFF, 8'h03);
        rchk(4'h1, 8'h7F, 8'h0F);
        rchk(4'h2, 8'h08, 8'h08);
        i_ppes_host.wr(4'h4, 8'h08);
        rchk(4'h4, 8'hFF, 8'h08);
        chk({7'h00, irq}, 8'h01);
        i_ppes_host.wr(4'h3, 8'h08);
        @(negedge core_clk);
        chk({7'h00, irq}, 8'h00);
        $display("boot and interrupt done");
    endtask
    task t_enable;
        i_ppes_host.wr(4'h0, 8'h02);
        won(1'b0, 10);
        i_ppes_host.wr(4'h0, 8'h03);
        won(1'b1, 30);
        i_ppes_host.pins(1'b1, 1'b0);
        won(1'b0, 10);
        i_ppes_host.pins(1'b1, 1'b1);
        rchk(4'h1, 8'h40, 8'h40);
        offn(3);
        won(1'b1, 30);
        $display("enable retry done");
    endtask
    task t_attach;
        @(posedge core_clk);
        sink_attached <= 1'b0;
        @(posedge core_clk);
        sink_attached <= 1'b1;
        offn(6);
        won(1'b1, 30);
        @(posedge core_clk);
        sink_attached <= 1'b0;
        offn(12);
        i_ppes_host.wr(4'h0, 8'h07);
        won(1'b1, 30);
        i_ppes_host.wr(4'h0, 8'h03);
        won(1'b0, 10);
        @(posedge core_clk);
        sink_attached <= 1'b1;
        won(1'b1, 30);
        $display("attach and bypass done");
    endtask
    task t_power;
        @(posedge core_clk);
        switch_supply_good <= 1'b0;
        @(negedge core_clk);
        chk({7'h00, regulator_on}, 8'h00);
        @(posedge core_clk);
        switch_supply_good <= 1'b1;
        i_ppes_host.pins(1'b0, 1'b0);
        repeat (6) @(negedge core_clk);
        chk({5'h00, standby, regulator_on, attention}, 8'h05);
        i_ppes_host.pins(1'b1, 1'b0);
        repeat (4) @(negedge core_clk);
        chk({6'h00, standby, regulator_on}, 8'h01);
        i_ppes_host.cfg(8'h03);
        offn(20);
        i_ppes_host.pins(1'b1, 1'b1);
        won(1'b1, 30);
        @(posedge core_clk);
        internal_supply_good <= 1'b0;
        won(1'b0, 10);
        i_ppes_host.wr(4'h0, 8'h03);
        internal_supply_good <= 1'b1;
        rchk(4'h0, 8'hFF, 8'h00);
        $display("power sequencing done");
    endtask
    task t_mode;
        // each step after the first, which sets all four, drops the highest-precedence input that is still set
        for (int i = 0; i < 4; i++)
        begin
            @(posedge core_clk);
            mode_in <= 4'hF >> i;
            repeat (3) @(negedge core_clk);
            chk({6'h00, charge_mode}, i[7:0]);
        end
        $display("charge mode done");
    endtask
    task t_alone;
        @(posedge core_clk);
        standalone_variant <= 1'b1;
        i_ppes_host.pins(1'b1, 1'b1);
        won(1'b1, 40);
        chk({7'h00, attention}, 8'h00);
        rchk(4'h0, 8'h01, 8'h01);
        $display("standalone done");
    endtask
    initial
    begin
        n_errors = 0;
        cmp_count = 0;
        rst_b = 1'b0;
        switch_supply_good = 1'b1;
        internal_supply_good = 1'b1;
        standalone_variant = 1'b0;
        sink_attached = 1'b1;
        mode_in = 4'h1;
        repeat (12) @(posedge core_clk);
        rst_b <= 1'b1;
        @(negedge core_clk);
        t_boot;
        t_enable;
        t_attach;
        t_power;
        t_mode;
        t_alone;
        summarize;
    end
    // the run needs a few hundred cycles
    initial
    begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        summarize;
    end
endmodule
bind ppes_sequencer ppes_props #(.ENABLE_RETRY_CYC(ENABLE_RETRY_CYC),
    .DETACH_RETRY_CYC(DETACH_RETRY_CYC)) i_ppes_props (.core_clk, .rst_b, .system_enable_pin,
    .converter_enable_pin, .switch_supply_good, .internal_supply_good, .standalone_variant,
    .sink_attached, .reg_rd, .reg_rdata, .converter_on, .isolation_gate_drive, .regulator_on,
    .standby, .attention);
